/* rtl/rsar_consts.svh */
/*
 * Constants of the resistance sensor autorange readout: calibration slots,
 * current value points, ADC target window and timing.
 * Assumes inclusion by bare name from the package and the readout module.
 */
`ifndef RSAR_CONSTS_SVH
`define RSAR_CONSTS_SVH

// ============================================================
// Current ranges and values
`define RSAR_RANGE_TOP      2'h3
`define RSAR_VALUE_LOW      6'h06
`define RSAR_VALUE_HIGH     6'h3C
`define RSAR_VALUE_MAX      6'h3F
`define RSAR_INTERP_SPAN    8'sh36

// ============================================================
// Calibration slots: 0..15 current, then amplifier gain and offset
`define RSAR_CAL_SLOTS      18
`define RSAR_CAL_GAIN       5'h10
`define RSAR_CAL_OFFSET     5'h11
`define RSAR_GAIN_UNITY     16'h4000
`define RSAR_GAIN_SHIFT     14
`define RSAR_RESET_CODE     16'h0000

// ============================================================
// Target: 1.05 mV x1000 or 10.5 mV x100 give the same amplified level
`define RSAR_TARGET_CNT     18'h0_1AE1
`define RSAR_TARGET_BAND    18'h0_0040
`define RSAR_STAB_RATIO     8'h00C8

// ============================================================
// Option switches: bit of switch 3, closed enables control correction
`define RSAR_SW_THERM       2

// ============================================================
// Timing
`define RSAR_CLK_MHZ        200
`define RSAR_SETTLE_NS      1000

`endif

/* rtl/rsar_pkg.sv */
/*
 * Types of the resistance sensor autorange readout.
 * Assumes the constants header sits beside it.
 */
`include "rsar_consts.svh"

package rsar_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SET_DAC,
        ST_SETTLE,
        ST_CONVERT,
        ST_WAIT_ADC,
        ST_EVAL
    } rsar_state_t;

    typedef struct packed {
        rsar_state_t                   state;
        logic [`RSAR_CAL_SLOTS-1:0][15:0] cal;
        logic [1:0]                    range;
        logic [5:0]                    value;
        logic                          reverse;
        logic                          locked;
        logic                          stable;
        logic                          have_prev;
        logic                          host_pend;
        logic [15:0]                   settle_cnt;
        logic signed [17:0]            v_fwd;
        logic signed [17:0]            v_prev;
        logic signed [17:0]            thermal;
        logic signed [17:0]            sensor_v;
        logic [15:0]                   dac_code;
        logic                          dac_load;
        logic                          adc_start;
        logic                          done;
    } rsar_regs_t;

endpackage

/* rtl/rsar_readout.sv */
/*
 * Sequencer of the resistance sensor input: autoranges a bipolar current
 * DAC, reads the amplified sensor voltage from a 15-bit ADC, reverses the
 * current for thermal EMF correction and applies stored calibration.
 * Assumes the DAC latches o_dac_code on o_dac_load, the ADC answers each
 * o_adc_start with one i_adc_done pulse, and the host pulses i_update_req.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rsar_consts.svh"

// Behaviour
// - Four current ranges, decade each, range 0 lowest to range 3 highest.
// - Each range offers 64 selectable current values.
// - Value 60 of a range equals value 6 of the next range up.
// - One 16-bit bipolar DAC code sets current magnitude and polarity.
// - Sixteen current constants: per range, values 6 and 60, both polarities.
// - Sample mode steps current as fast as possible to reach target voltage.
// - Amplifier gain 1000 or 100 gives the same target count at the ADC.
// - Sensor signal digitised by a 15-bit ADC sequenced here.
// - Stored amplifier gain and offset applied to every reading.
// - Control output held while current is reversed during control.
// - Option switch 3 closed enables control thermal correction.
// - Identification sign is plus when thermal correction enabled.
// - On reaching target, reverse current and compute a thermal value.
// - Stable within 0.5%: forward and reverse reading per host update.
// - Change over 0.5%: stop reversing, keep last thermal value.
module rsar_readout #(
    parameter int SETTLE_NS = `RSAR_SETTLE_NS
) (
    // Clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_srst,
    // Host side
    input  wire logic               i_update_req,
    input  wire logic               i_control_mode,
    input  wire logic [3:0]         i_input_option_dipswitch,
    output logic                    o_update_done,
    output logic signed [17:0]      o_sensor_v,
    output logic signed [17:0]      o_thermal,
    output logic                    o_id_sign,
    output logic                    o_locked,
    output logic                    o_stable,
    // Calibration store
    input  wire logic               i_cal_wr,
    input  wire logic [4:0]         i_cal_addr,
    input  wire logic [15:0]        i_cal_data,
    // Current source
    output logic [15:0]             o_dac_code,
    output logic                    o_dac_load,
    output logic [1:0]              o_range,
    output logic [5:0]              o_value,
    output logic                    o_reverse,
    output logic                    o_ctrl_hold,
    // Converter
    output logic                    o_adc_start,
    input  wire logic               i_adc_done,
    input  wire logic signed [14:0] i_adc_data
);

    // ============================================================
    // Timing
    localparam int SETTLE_CYC_RAW = (SETTLE_NS * `RSAR_CLK_MHZ + 999) / 1000;
    localparam int SETTLE_CYC     = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;

    if (SETTLE_CYC > 65535) begin : g_bad_settle
        $error("SETTLE_NS too long for the settle counter");
    end

    rsar_pkg::rsar_regs_t r;
    rsar_pkg::rsar_regs_t next_r;

    // ============================================================
    // DAC code from calibration
    // Linear interpolation between the two calibrated points of the range;
    // values below 6 or above 60 extrapolate along the same line.
    function automatic logic [15:0] dac_interp(
        input logic [15:0] c_lo,
        input logic [15:0] c_hi,
        input logic [5:0]  val
    );
        logic signed [16:0] span;
        logic signed [7:0]  step;
        logic signed [24:0] prod;
        logic signed [24:0] part;
        span = $signed({c_hi[15], c_hi}) - $signed({c_lo[15], c_lo});
        step = $signed({2'h0, val}) - $signed({2'h0, `RSAR_VALUE_LOW});
        prod = 25'(span * step);
        part = prod / `RSAR_INTERP_SPAN;
        dac_interp = 16'(c_lo + part[15:0]);
    endfunction

    // ============================================================
    // Next state
    always_comb begin
        logic [3:0]         slot;
        logic signed [16:0] adc_diff;
        logic signed [33:0] adc_gain;
        logic signed [17:0] v_now;
        logic signed [17:0] v_abs;
        logic signed [17:0] d_abs;
        logic [25:0]        d_scaled;
        logic               therm_on;
        logic               may_rev;
        logic               big_move;
        next_r = r;
        slot = 4'h0;
        adc_diff = 17'sh0_0000;
        adc_gain = 34'sh0_0000_0000;
        v_now = 18'sh0_0000;
        v_abs = 18'sh0_0000;
        d_abs = 18'sh0_0000;
        d_scaled = 26'h000_0000;
        therm_on = i_input_option_dipswitch[`RSAR_SW_THERM];
        may_rev = !i_control_mode || therm_on;
        big_move = 1'b0;
        next_r.dac_load = 1'b0;
        next_r.adc_start = 1'b0;
        next_r.done = 1'b0;
        if (i_update_req) begin
            next_r.host_pend = 1'b1;
        end
        if (i_cal_wr && i_cal_addr < 5'(`RSAR_CAL_SLOTS)) begin
            next_r.cal[i_cal_addr] = i_cal_data;
        end

        adc_diff = $signed({{2{i_adc_data[14]}}, i_adc_data})
                 - $signed({r.cal[`RSAR_CAL_OFFSET][15], r.cal[`RSAR_CAL_OFFSET]});
        adc_gain = 34'(adc_diff * $signed(r.cal[`RSAR_CAL_GAIN]));
        v_now = adc_gain[`RSAR_GAIN_SHIFT+17:`RSAR_GAIN_SHIFT];
        v_abs = v_now[17] ? -v_now : v_now;

        case (r.state)
            rsar_pkg::ST_IDLE: begin
                if (!r.locked || r.host_pend) begin
                    // A request in this very cycle stays pending, set wins
                    next_r.host_pend = i_update_req;
                    next_r.reverse = 1'b0;
                    next_r.state = rsar_pkg::ST_SET_DAC;
                end
            end
            rsar_pkg::ST_SET_DAC: begin
                slot = {r.range, r.reverse, 1'b0};
                next_r.dac_code = dac_interp(r.cal[slot], r.cal[slot + 4'h1], r.value);
                next_r.dac_load = 1'b1;
                next_r.settle_cnt = 16'(SETTLE_CYC);
                next_r.state = rsar_pkg::ST_SETTLE;
            end
            rsar_pkg::ST_SETTLE: begin
                if (r.settle_cnt <= 16'h0001) begin
                    next_r.state = rsar_pkg::ST_CONVERT;
                end else begin
                    next_r.settle_cnt = r.settle_cnt - 16'h0001;
                end
            end
            rsar_pkg::ST_CONVERT: begin
                next_r.adc_start = 1'b1;
                next_r.state = rsar_pkg::ST_WAIT_ADC;
            end
            rsar_pkg::ST_WAIT_ADC: begin
                if (i_adc_done) begin
                    next_r.state = rsar_pkg::ST_EVAL;
                    if (r.reverse) begin
                        next_r.thermal = 18'((19'(r.v_fwd) + 19'(v_now)) >>> 1);
                        next_r.sensor_v = 18'((19'(r.v_fwd) - 19'(v_now)) >>> 1);
                    end else begin
                        next_r.v_fwd = v_now;
                    end
                end
            end
            rsar_pkg::ST_EVAL: begin
                next_r.state = rsar_pkg::ST_IDLE;
                v_abs = r.v_fwd[17] ? -r.v_fwd : r.v_fwd;
                d_abs = (r.v_fwd > r.v_prev) ? r.v_fwd - r.v_prev : r.v_prev - r.v_fwd;
                d_scaled = 26'(d_abs) * 26'(`RSAR_STAB_RATIO);
                big_move = r.have_prev && (d_scaled > 26'(v_abs));
                // One count target for both gains
                if (r.reverse) begin
                    next_r.reverse = 1'b0;
                    next_r.done = r.locked;
                    next_r.locked = 1'b1;
                end else if (v_abs + `RSAR_TARGET_BAND < `RSAR_TARGET_CNT) begin
                    next_r.locked = 1'b0;
                    if (r.value == `RSAR_VALUE_HIGH && r.range != `RSAR_RANGE_TOP) begin
                        next_r.range = r.range + 2'h1;
                        next_r.value = `RSAR_VALUE_LOW;
                    end else if (r.value != `RSAR_VALUE_MAX) begin
                        next_r.value = r.value + 6'h01;
                    end
                end else if (v_abs > `RSAR_TARGET_CNT + `RSAR_TARGET_BAND) begin
                    next_r.locked = 1'b0;
                    if (r.value == `RSAR_VALUE_LOW && r.range != 2'h0) begin
                        next_r.range = r.range - 2'h1;
                        next_r.value = `RSAR_VALUE_HIGH;
                    end else if (r.value != 6'h00) begin
                        next_r.value = r.value - 6'h01;
                    end
                end else begin
                    next_r.v_prev = r.v_fwd;
                    next_r.have_prev = 1'b1;
                    next_r.stable = !big_move;
                    if (may_rev && (!r.locked || !big_move)) begin
                        next_r.reverse = 1'b1;
                        next_r.state = rsar_pkg::ST_SET_DAC;
                    end else begin
                        next_r.sensor_v = 18'(r.v_fwd - r.thermal);
                        next_r.done = r.locked;
                        next_r.locked = 1'b1;
                    end
                end
            end
            default: begin
                next_r.state = rsar_pkg::ST_IDLE;
            end
        endcase

        if (i_srst) begin
            next_r = '0;
            next_r.state = rsar_pkg::ST_IDLE;
            next_r.dac_code = `RSAR_RESET_CODE;
            next_r.cal[`RSAR_CAL_GAIN] = `RSAR_GAIN_UNITY;
        end
    end

    // ============================================================
    // State register
    always_ff @(posedge i_clk) begin
        r <= next_r;
    end

    // ============================================================
    // Outputs
    assign o_update_done = r.done;
    assign o_sensor_v = r.sensor_v;
    assign o_thermal = r.thermal;
    assign o_id_sign = i_input_option_dipswitch[`RSAR_SW_THERM];
    assign o_locked = r.locked;
    assign o_stable = r.stable;
    assign o_dac_code = r.dac_code;
    assign o_dac_load = r.dac_load;
    assign o_range = r.range;
    assign o_value = r.value;
    assign o_reverse = r.reverse;
    assign o_ctrl_hold = i_control_mode && r.reverse;
    assign o_adc_start = r.adc_start;

endmodule

`default_nettype wire

/* verification/rsar_readout_properties.sv */
/* Port-timing checker of the readout.
   Bound into rsar_readout; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
`include "rsar_consts.svh"
module rsar_readout_properties #(
    parameter int SETTLE_NS = `RSAR_SETTLE_NS
) (
    // Clock and reset
    input wire logic        i_clk,
    input wire logic        i_srst,
    // Watched ports
    input wire logic        i_control_mode,
    input wire logic [3:0]  i_input_option_dipswitch,
    input wire logic        o_update_done,
    input wire logic        o_id_sign,
    input wire logic        o_locked,
    input wire logic [15:0] o_dac_code,
    input wire logic        o_dac_load,
    input wire logic [1:0]  o_range,
    input wire logic [5:0]  o_value,
    input wire logic        o_reverse,
    input wire logic        o_ctrl_hold,
    input wire logic        o_adc_start
);
    // ====
    // Properties
    // Load cycle plus the settle count, rounded up as the design does
    localparam int SCYC = (SETTLE_NS * `RSAR_CLK_MHZ + 999) / 1000;
    localparam int DLY  = ((SCYC < 1) ? 1 : SCYC) + 1;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    sequence s_up;
        o_range == $past(o_range) + 2'h1 && $past(o_value) == 6'h3C && o_value == 6'h06;
    endsequence
    sequence s_down;
        o_range == $past(o_range) - 2'h1 && $past(o_value) == 6'h06 && o_value == 6'h3C;
    endsequence
    AST_ID_SIGN: assert property (o_id_sign == i_input_option_dipswitch[`RSAR_SW_THERM])
        else $error("id sign wrong");
    AST_CTRL_HOLD: assert property (o_ctrl_hold == (i_control_mode && o_reverse))
        else $error("control hold wrong");
    AST_START: assert property (o_dac_load |-> ##DLY o_adc_start)
        else $error("conversion start not on time");
    AST_SETTLE: assert property (o_dac_load |=> ($stable(o_dac_code) && !o_adc_start) [*8])
        else $error("dac code moved while settling");
    AST_RANGE: assert property (o_range != $past(o_range) |-> s_up or s_down)
        else $error("range step not at overlap");
    AST_DONE: assert property (o_update_done |-> o_locked)
        else $error("update done while unlocked");
    AST_REV: assert property ($rose(o_reverse) |-> ($stable(o_range) && $stable(o_value)) ##1 o_dac_load)
        else $error("reverse not at a held point");
    AST_SW3: assert property (($rose(o_reverse) && $past(i_control_mode)) |-> $past(i_input_option_dipswitch[`RSAR_SW_THERM]))
        else $error("reversed with correction off");
endmodule
bind rsar_readout rsar_readout_properties #(.SETTLE_NS(SETTLE_NS)) u_props (.*);
`default_nettype wire

/* verification/rsar_sensor_model.sv */
/* Sensor, amplifier and converter seen from the readout.
   Assumes one conversion at a time, started by a one-cycle pulse. */
`timescale 1ns/1ps
`default_nettype none
module rsar_sensor_model (
    // Clock
    input  wire logic               i_clk,
    // From the readout
    input  wire logic               i_adc_start,
    input  wire logic [1:0]         i_range,
    input  wire logic               i_reverse,
    // Scenario settings
    input  wire logic [1:0]         i_lock_range,
    input  wire logic signed [14:0] i_mag,
    input  wire logic signed [14:0] i_emf,
    input  wire logic               i_slow,
    // To the readout
    output logic                    o_adc_done,
    output logic signed [14:0]      o_adc_data
);
    // ====
    // Conversion
    int cnt = 0;
    initial begin
        o_adc_done = 1'b0;
        o_adc_data = 15'h0000;
    end
    always @(posedge i_clk) begin
        o_adc_done <= 1'b0;
        // Data not valid between answers, so it keeps toggling
        o_adc_data <= ~o_adc_data;
        if (i_adc_start) begin
            cnt <= i_slow ? 40 : 3;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end else if (cnt == 1) begin
            cnt <= 0;
            o_adc_done <= 1'b1;
            // Amplified level; thermal emf keeps its sign
            if (i_range < i_lock_range)
                o_adc_data <= 15'h0064;
            else if (i_range > i_lock_range)
                o_adc_data <= 15'h3FFF;
            else
                o_adc_data <= i_reverse ? i_emf - i_mag : i_emf + i_mag;
        end
    end
endmodule
`default_nettype wire

/* verification/rsar_readout_test.sv */
/* Self-checking bench of the readout.
   Assumes the design, the checker and the sensor model compile first. */
`timescale 1ns/1ps
`default_nettype none
`include "rsar_consts.svh"
module rsar_readout_test;
    // ====
    // Signals
    localparam int TGT = `RSAR_TARGET_CNT;
    logic i_clk = 1'b0, i_srst = 1'b1, i_update_req = 1'b0, i_control_mode = 1'b0;
    logic [3:0] i_input_option_dipswitch = 4'h0;
    logic i_cal_wr = 1'b0, i_adc_done, slow = 1'b0;
    logic [4:0] i_cal_addr = 5'h00;
    logic [15:0] i_cal_data = 16'h0000, o_dac_code, c_fwd, c_rev, seed = 16'hBEB3;
    logic signed [14:0] i_adc_data, mag = 15'h1AE1, emf = 15'h0000;
    logic o_update_done, o_id_sign, o_locked, o_stable, o_dac_load, o_reverse;
    logic o_ctrl_hold, o_adc_start;
    logic signed [17:0] o_sensor_v, o_thermal;
    logic [1:0] o_range, lock_range = 2'h1;
    logic [5:0] o_value;
    logic [36:0] q[$], ex;
    int miscompares = 0, n_checks = 0, cycles = 0, gain = 16384, off = 0, pf = 0, th = 0;
    always #2.5 i_clk = ~i_clk;
    // Short settle keeps the run brief
    rsar_readout #(.SETTLE_NS(50)) DUT (.*);
    rsar_sensor_model u_sensor (.i_clk(i_clk), .i_adc_start(o_adc_start), .i_range(o_range),
        .i_reverse(o_reverse), .i_lock_range(lock_range), .i_mag(mag), .i_emf(emf),
        .i_slow(slow), .o_adc_done(i_adc_done), .o_adc_data(i_adc_data));
    // ====
    // Helpers
    function automatic logic [15:0] rnd();
        seed ^= seed << 7;
        seed ^= seed >> 9;
        seed ^= seed << 8;
        return seed;
    endfunction
    function automatic int ab(input int x);
        return x < 0 ? -x : x;
    endfunction
    function automatic int conv(input int a);
        return ((a - off) * gain) >>> 14;
    endfunction
    task automatic chk(input string nm, input logic [17:0] exp, input logic [17:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wait_sig(ref logic s, input logic v);
        for (int k = 0; k < 9000 && s !== v; k++) @(negedge i_clk);
        if (s !== v)
            chk("wait", 18'(v), 18'(s));
    endtask
    task automatic cal(input logic [4:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_cal_wr <= 1'b1;
        i_cal_addr <= a;
        i_cal_data <= d;
    endtask
    // Without req only the model is stepped, mirroring the first lock
    task automatic update(input int e, input bit req);
        int vf;
        int vr;
        int sv;
        bit st;
        logic [15:0] t;
        t = rnd();
        @(posedge i_clk);
        emf <= 15'(e);
        slow <= t[0];
        i_update_req <= req;
        vf = conv(int'(mag) + e);
        vr = conv(e - int'(mag));
        st = ab(vf - pf) * 200 <= ab(vf);
        if (!req || (st && (!i_control_mode || i_input_option_dipswitch[2]))) begin
            th = (vf + vr) >>> 1;
            sv = (vf - vr) >>> 1;
        end else begin
            sv = vf - th;
        end
        pf = vf;
        if (req) begin
            q.push_back({st, 18'(sv), 18'(th)});
            @(posedge i_clk);
            i_update_req <= 1'b0;
            wait_sig(o_update_done, 1'b1);
        end
        $display("test update emf %0d done", e);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ====
    // Monitor and timeout
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            report_and_stop();
        end
        if (o_update_done === 1'b1) begin
            if (q.size() == 0) begin
                chk("update_done", 18'h0, 18'h1);
            end else begin
                ex = q.pop_front();
                chk("sensor_v", ex[35:18], o_sensor_v);
                chk("thermal", ex[17:0], o_thermal);
                chk("stable", 18'(ex[36]), 18'(o_stable));
            end
        end
        if (o_dac_load === 1'b1)
            chk("ctrl_hold", 18'(i_control_mode & o_reverse), 18'(o_ctrl_hold));
        if (o_dac_load === 1'b1 && o_range === 2'h1 && o_value === 6'h06)
            chk("dac_code", 18'(o_reverse ? c_rev : c_fwd), 18'(o_dac_code));
    end
    // ====
    // Sequence
    initial begin
        repeat (10) @(posedge i_clk);
        chk("locked", 18'h0, 18'(o_locked));
        chk("dac_load", 18'h0, 18'(o_dac_load));
        i_srst <= 1'b0;
        c_fwd = rnd();
        c_rev = rnd();
        cal(5'h04, c_fwd);
        cal(5'h06, c_rev);
        @(posedge i_clk);
        i_cal_wr <= 1'b0;
        wait_sig(o_locked, 1'b1);
        chk("range", 18'h1, 18'(o_range));
        chk("value", 18'h6, 18'(o_value));
        update(0, 1'b0);
        update(0, 1'b1);
        for (int i = 0; i < 3; i++)
            update(int'(rnd() % 16'h001F) - 15, 1'b1);
        update(60, 1'b1);
        cal(5'h10, 16'h2000);
        cal(5'h11, 16'h000A);
        @(posedge i_clk);
        i_cal_wr <= 1'b0;
        mag <= 15'(2 * TGT + 10);
        gain = 8192;
        off = 10;
        update(60, 1'b1);
        @(posedge i_clk);
        i_control_mode <= 1'b1;
        update(60, 1'b1);
        chk("id_sign", 18'h0, 18'(o_id_sign));
        // Option switch 3 closes: bit 2 of the dipswitch input is driven high
        @(posedge i_clk);
        i_input_option_dipswitch <= 4'h4;
        update(60, 1'b1);
        chk("id_sign", 18'h1, 18'(o_id_sign));
        @(posedge i_clk);
        i_control_mode <= 1'b0;
        lock_range <= 2'h0;
        i_update_req <= 1'b1;
        @(posedge i_clk);
        i_update_req <= 1'b0;
        wait_sig(o_locked, 1'b0);
        wait_sig(o_locked, 1'b1);
        chk("range", 18'h0, 18'(o_range));
        chk("value", 18'h3C, 18'(o_value));
        chk("pending", 18'h0, 18'(q.size()));
        $display("test range down done");
        report_and_stop();
    end
endmodule
`default_nettype wire
